// ===== rtl/icsm_clock_generator.sv
/*
 * Clock generator control: registers, output source switching, loop
 * enable, reference and bus dividers, stop gating, oscillator status.
 * Assumes clocks arrive as one-cycle tick pulses synchronous to clock_i
 * and that the analog loop and oscillators sit outside this module.
 */
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ns

module icsm_clock_generator
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire icsm_pkg::icsm_bus_req_type bus_i,
    output logic [7:0] rdata_o,
    input wire logic loop_tick_i,
    input wire logic internal_tick_i,
    input wire logic external_tick_i,
    input wire logic oscillator_done_i,
    input wire logic chip_stop_i,
    input wire logic debug_halt_state_i,
    output logic [7:0] coarse_trim_o,
    output logic fine_period_adjust_o,
    output logic loop_enable_o,
    output logic loop_restart_o,
    output logic divided_reference_tick_o,
    output logic generator_output_tick_o,
    output logic debug_link_tick_o,
    output logic internal_reference_tick_o,
    output logic external_reference_tick_o,
    output logic internal_reference_run_o,
    output logic external_reference_run_o,
    output logic oscillator_high_range_o,
    output logic oscillator_high_gain_o,
    output icsm_pkg::icsm_mode_type mode_o
);
    import icsm_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Registers and state

    icsm_control1_type control1;
    icsm_control2_type control2;
    logic [7:0] coarse_trim;
    logic fine_trim;
    logic oscillator_ready_flag;
    logic [1:0] active_mode_report;
    logic [1:0] active_src;
    logic [1:0] pending_src;
    logic [2:0] switch_cnt;
    logic [6:0] ref_cnt;
    logic [2:0] bus_cnt;
    logic prev_ref_select;
    logic relock_pending;
    logic [1:0] relock_cnt;
    logic prev_osc_request;
    logic prev_ext_enable;

    ////////////////////////////////////////////////////////////////////
    // Register port decode

    wire wr_control1 = bus_i.wr && (bus_i.addr == ADDR_CONTROL1);
    wire wr_control2 = bus_i.wr && (bus_i.addr == ADDR_CONTROL2);
    wire wr_trim = bus_i.wr && (bus_i.addr == ADDR_TRIM);
    wire wr_status = bus_i.wr && (bus_i.addr == ADDR_STATUS);

    // Status image; upper nibble is fixed zero
    wire [7:0] status_value = {STATUS_RESERVED, active_mode_report,
        oscillator_ready_flag, fine_trim};

    // Read selection
    wire [7:0] read_value =
        (bus_i.addr == ADDR_CONTROL1) ? control1 :
        (bus_i.addr == ADDR_CONTROL2) ? control2 :
        (bus_i.addr == ADDR_TRIM) ? coarse_trim : status_value;

    ////////////////////////////////////////////////////////////////////
    // Mode decode

    wire [1:0] req_src = (control1.output_source_select == SRC_RESERVED)
        ? SRC_LOOP : control1.output_source_select;
    wire ref_internal = control1.loop_reference_select;
    wire low_power_cut = control2.low_power_select && !debug_halt_state_i;
    // Low power may stop the loop only once both request and active are bypassed
    wire loop_cut = low_power_cut && (req_src != SRC_LOOP)
        && (active_src != SRC_LOOP);
    wire loop_on = !loop_cut && !chip_stop_i;

    // Current mode from the clock actually in use
    icsm_mode_type cur_mode;
    assign cur_mode =
        (active_src == SRC_LOOP) ? (ref_internal ? internal_engaged_mode
            : external_engaged_mode) :
        (active_src == SRC_INTERNAL) ? (low_power_cut
            ? internal_bypass_low_power_mode : internal_bypass_mode) :
        (low_power_cut ? external_bypass_low_power_mode
            : external_bypass_mode);

    wire ext_mode = (cur_mode == external_engaged_mode)
        || (cur_mode == external_bypass_mode)
        || (cur_mode == external_bypass_low_power_mode);
    wire int_mode = !ext_mode;

    ////////////////////////////////////////////////////////////////////
    // Source ticks and dividers

    // Tick of the clock that the pending switch waits for
    wire new_tick = (req_src == SRC_LOOP) ? loop_tick_i :
        (req_src == SRC_INTERNAL) ? internal_tick_i : external_tick_i;
    wire act_tick = (active_src == SRC_LOOP) ? loop_tick_i :
        (active_src == SRC_INTERNAL) ? internal_tick_i : external_tick_i;
    wire ref_tick = ref_internal ? internal_tick_i : external_tick_i;
    wire [6:0] ref_last =
        7'((8'h01 << control1.reference_divider) - 8'h01);
    wire [2:0] bus_last =
        3'((4'h1 << control2.bus_divider) - 4'h1);
    wire ref_hit = ref_tick && (ref_cnt >= ref_last);
    wire bus_hit = act_tick && (bus_cnt >= bus_last);

    ////////////////////////////////////////////////////////////////////
    // Control registers, reset to internal engaged

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            control1 <= CONTROL1_RESET;
            control2 <= CONTROL2_RESET;
        end
        else
        begin
            if (wr_control1)
                control1 <= bus_i.wdata;
            if (wr_control2)
                control2 <= bus_i.wdata;
        end
    end

    // Trim values hold through reset
    always_ff @(posedge clock_i)
    begin
        if (wr_trim)
            coarse_trim <= bus_i.wdata;
        if (wr_status)
            fine_trim <= bus_i.wdata[STATUS_FINE_BIT];
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
            rdata_o <= 8'h00;
        else
            rdata_o <= bus_i.rd ? read_value : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // Output source switching

    wire switch_done = (req_src != active_src) && (req_src == pending_src)
        && new_tick && (switch_cnt == SWITCH_TICKS - 3'h1);

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            active_src <= SRC_LOOP;
            pending_src <= SRC_LOOP;
            switch_cnt <= 3'h0;
            active_mode_report <= SRC_LOOP;
        end
        else
        begin
            pending_src <= req_src;
            if (req_src == active_src || req_src != pending_src)
                switch_cnt <= 3'h0;
            else if (switch_done)
            begin
                active_src <= req_src;
                switch_cnt <= 3'h0;
            end
            else if (new_tick)
                switch_cnt <= switch_cnt + 3'h1;
            active_mode_report <= active_src;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Reference and bus dividers, loop relock after reference change

    wire ref_changed = (prev_ref_select != ref_internal);

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ref_cnt <= 7'h00;
            bus_cnt <= 3'h0;
            prev_ref_select <= 1'b1;
            relock_pending <= 1'b0;
            relock_cnt <= 2'h0;
        end
        else
        begin
            if (ref_tick)
                ref_cnt <= ref_hit ? 7'h00 : ref_cnt + 7'h01;
            if (act_tick)
                bus_cnt <= bus_hit ? 3'h0 : bus_cnt + 3'h1;
            prev_ref_select <= ref_internal;
            if (ref_changed)
            begin
                relock_pending <= 1'b1;
                relock_cnt <= 2'h0;
            end
            else if (relock_pending && ref_hit)
            begin
                if (relock_cnt == RELOCK_TICKS - 2'h1)
                    relock_pending <= 1'b0;
                relock_cnt <= relock_cnt + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Oscillator ready flag

    wire ready_set = oscillator_done_i && control2.oscillator_request
        && (control2.external_reference_enable || ext_mode);
    wire ready_clear =
        (prev_osc_request && !control2.oscillator_request)
        || (prev_ext_enable && !control2.external_reference_enable);

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            oscillator_ready_flag <= 1'b0;
            prev_osc_request <= 1'b0;
            prev_ext_enable <= 1'b0;
        end
        else
        begin
            prev_osc_request <= control2.oscillator_request;
            prev_ext_enable <= control2.external_reference_enable;
            if (ready_set)
                oscillator_ready_flag <= 1'b1;
            else if (ready_clear)
                oscillator_ready_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock outputs with stop gating

    wire int_keep = control1.internal_reference_enable
        && control1.internal_stop_keepalive;
    wire ext_keep = control2.external_reference_enable
        && control2.external_stop_keepalive;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            loop_enable_o <= 1'b1;
            loop_restart_o <= 1'b0;
            divided_reference_tick_o <= 1'b0;
            generator_output_tick_o <= 1'b0;
            debug_link_tick_o <= 1'b0;
            internal_reference_tick_o <= 1'b0;
            external_reference_tick_o <= 1'b0;
            internal_reference_run_o <= 1'b1;
            external_reference_run_o <= 1'b0;
            mode_o <= internal_engaged_mode;
        end
        else
        begin
            loop_enable_o <= loop_on;
            loop_restart_o <= relock_pending && ref_hit && !ref_changed
                && (relock_cnt == RELOCK_TICKS - 2'h1);
            divided_reference_tick_o <= ref_hit && !chip_stop_i;
            generator_output_tick_o <= bus_hit && !chip_stop_i;
            debug_link_tick_o <= loop_tick_i && loop_on;
            internal_reference_tick_o <= internal_tick_i
                && control1.internal_reference_enable
                && (!chip_stop_i || int_keep);
            external_reference_tick_o <= external_tick_i
                && control2.external_reference_enable
                && (!chip_stop_i || ext_keep);
            internal_reference_run_o <= chip_stop_i ? int_keep
                : (control1.internal_reference_enable || int_mode
                   || req_src == SRC_INTERNAL);
            external_reference_run_o <= chip_stop_i ? ext_keep
                : (control2.external_reference_enable || ext_mode
                   || req_src == SRC_EXTERNAL);
            mode_o <= cur_mode;
        end
    end

    // Trim and oscillator settings straight from registers
    assign coarse_trim_o = coarse_trim;
    assign fine_period_adjust_o = fine_trim;
    assign oscillator_high_range_o = control2.range_select;
    assign oscillator_high_gain_o = control2.high_gain_select;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);

    sequence s_status_read;
        bus_i.rd && bus_i.addr == ADDR_STATUS;
    endsequence

    sequence s_select_write;
        wr_control1 && bus_i.wdata[7:6] != control1.output_source_select;
    endsequence

    AST_STATUS_RESERVED_ZERO: assert property (
        s_status_read |=> rdata_o[7:4] == 4'h0)
        else $error("status reserved bits not zero");

    AST_MODE_REPORT_DELAYED: assert property (
        s_select_write |=> $stable(active_mode_report))
        else $error("mode report moved with the select write");

    AST_SWITCH_NEEDS_TICK: assert property (
        $changed(active_src) |-> $past(new_tick) && $past(switch_cnt) == 3'h3)
        else $error("source switched without new clock cycles");

    AST_RESERVED_AS_LOOP: assert property (
        control1.output_source_select == SRC_RESERVED
            && active_src == SRC_LOOP |=> active_src == SRC_LOOP)
        else $error("reserved select left loop output");

    AST_READY_SETS: assert property (
        ready_set |=> oscillator_ready_flag)
        else $error("oscillator ready did not set");

    AST_READY_CLEARS: assert property (
        $fell(control2.oscillator_request) |=> !oscillator_ready_flag)
        else $error("oscillator ready did not clear");

    AST_LOW_POWER_LOOP_OFF: assert property (
        loop_cut |=> !loop_enable_o && !debug_link_tick_o)
        else $error("loop running in low power bypass");

    AST_STOP_STATIC: assert property (
        chip_stop_i |=> !generator_output_tick_o && !debug_link_tick_o)
        else $error("clock ticked during stop");

    AST_EXT_KEEPALIVE: assert property (
        chip_stop_i && ext_keep && external_tick_i
            |=> external_reference_tick_o)
        else $error("external output stopped despite keepalive");

    AST_BUS_DIV_ONE: assert property (
        control2.bus_divider == 2'h0 && act_tick && !chip_stop_i
            |=> generator_output_tick_o)
        else $error("divide-by-1 missed a tick");

    AST_NO_EARLY_RELOCK: assert property (
        ref_changed |=> !loop_restart_o [*2])
        else $error("relock came too early");

endmodule : icsm_clock_generator

// ===== common/icsm_pkg.sv
/*
 * Constants and types shared by the clock generator control block:
 * register offsets, reset values, field positions, source codes,
 * settling counts, mode names and the register port request bundle.
 * Assumes an 8-bit register port with a 2-bit address.
 */
package icsm_pkg;

    // Register offsets on the plain register port
    localparam logic [1:0] ADDR_CONTROL1 = 2'h0;
    localparam logic [1:0] ADDR_CONTROL2 = 2'h1;
    localparam logic [1:0] ADDR_TRIM = 2'h2;
    localparam logic [1:0] ADDR_STATUS = 2'h3;

    // Reset values: internal engaged mode, bus divide-by-2
    localparam logic [7:0] CONTROL1_RESET = 8'h04;
    localparam logic [7:0] CONTROL2_RESET = 8'h40;

    // Status register field positions
    localparam int STATUS_MODE_LSB = 2;
    localparam int STATUS_READY_BIT = 1;
    localparam int STATUS_FINE_BIT = 0;
    localparam logic [3:0] STATUS_RESERVED = 4'h0;

    // Output source codes, shared by select and mode report
    localparam logic [1:0] SRC_LOOP = 2'h0;
    localparam logic [1:0] SRC_INTERNAL = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;

    // Full cycles of the new clock before a source switch completes
    localparam logic [2:0] SWITCH_TICKS = 3'h4;
    // Divided reference cycles before the loop relocks
    localparam logic [1:0] RELOCK_TICKS = 2'h2;

    // First control register
    typedef struct packed {
        logic [1:0] output_source_select;
        logic [2:0] reference_divider;
        logic loop_reference_select;
        logic internal_reference_enable;
        logic internal_stop_keepalive;
    } icsm_control1_type;

    // Second control register
    typedef struct packed {
        logic [1:0] bus_divider;
        logic range_select;
        logic high_gain_select;
        logic low_power_select;
        logic oscillator_request;
        logic external_reference_enable;
        logic external_stop_keepalive;
    } icsm_control2_type;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] addr;
        logic [7:0] wdata;
    } icsm_bus_req_type;

    // Operating state of the generator
    typedef enum logic [2:0] {
        internal_engaged_mode,
        external_engaged_mode,
        internal_bypass_mode,
        internal_bypass_low_power_mode,
        external_bypass_mode,
        external_bypass_low_power_mode
    } icsm_mode_type;

endpackage : icsm_pkg

// ===== bench/icsm_clock_partner.sv
/*
 * Far side of the clock generator: loop, internal and external
 * reference tick sources and the oscillator start-up flag.
 * Assumes ticks are one-cycle pulses on the bench clock.
 */
`timescale 1ns/1ns

module icsm_clock_partner
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic loop_enable_i,
    input wire logic external_alive_i,
    output logic loop_tick_o,
    output logic internal_tick_o,
    output logic external_tick_o,
    output logic oscillator_done_o
);
    logic [3:0] phase;
    logic [3:0] warm;

    // Phase counter and oscillator warm-up count
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            phase <= 4'h0;
            warm <= 4'h0;
        end
        else
        begin
            phase <= phase + 4'h1;
            if (!external_alive_i)
                warm <= 4'h0;
            else if (warm != 4'hF)
                warm <= warm + 4'h1;
        end
    end

    // Loop ticks only while powered; dead oscillator gives no ticks
    assign loop_tick_o = loop_enable_i & phase[0];
    assign internal_tick_o = (phase[1:0] == 2'h3);
    assign external_tick_o = external_alive_i & (phase[2:0] == 3'h5);
    assign oscillator_done_o = (warm == 4'hF);
endmodule : icsm_clock_partner

// ===== bench/tb_internal_clock_source_modes.sv
/*
 * Self-checking bench for the clock generator control block.
 * Assumes the partner model supplies all tick inputs.
 */
`timescale 1ns/1ns

module tb_internal_clock_source_modes;
    import icsm_pkg::*;
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic [7:0] rexp;
    } icsm_row_type;
    logic clock_i, rstn_i, chip_stop_i, debug_i, ext_alive;
    logic loop_tick, int_tick, ext_tick, osc_done;
    icsm_bus_req_type bus_i;
    logic [7:0] rdata_o, trim_o, d;
    logic fine_o, loop_en_o, restart_o, gen_o, dbg_o, int_o, ext_o, erun_o;
    logic ref_o, irun_o;
    icsm_mode_type mode_o;
    logic [7:0] c_gen, c_dbg, c_int, c_ext, c_rst, c_ref;
    int num_errors = 0;
    int check_count = 0;
    icsm_row_type rows [9] = '{
        '{ADDR_CONTROL2, 8'h40, 8'h40}, '{ADDR_TRIM, 8'h5A, 8'h5A},
        // Status writes store only the fine bit, not the mode or ready bits
        '{ADDR_STATUS, 8'h0F, 8'h01}, '{ADDR_STATUS, 8'h0E, 8'h00},
        '{ADDR_STATUS, 8'h01, 8'h01}, '{ADDR_CONTROL1, 8'h06, 8'h06},
        '{ADDR_TRIM, 8'h00, 8'h00}, '{ADDR_TRIM, 8'hA5, 8'hA5},
        '{ADDR_CONTROL2, 8'h40, 8'h40}};

    icsm_clock_generator dut_u (.clock_i(clock_i), .rstn_i(rstn_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .loop_tick_i(loop_tick),
        .internal_tick_i(int_tick), .external_tick_i(ext_tick),
        .oscillator_done_i(osc_done), .chip_stop_i(chip_stop_i),
        .debug_halt_state_i(debug_i), .coarse_trim_o(trim_o),
        .fine_period_adjust_o(fine_o), .loop_enable_o(loop_en_o),
        .loop_restart_o(restart_o), .divided_reference_tick_o(ref_o),
        .generator_output_tick_o(gen_o), .debug_link_tick_o(dbg_o),
        .internal_reference_tick_o(int_o),
        .external_reference_tick_o(ext_o), .internal_reference_run_o(irun_o),
        .external_reference_run_o(erun_o), .oscillator_high_range_o(),
        .oscillator_high_gain_o(), .mode_o(mode_o));
    icsm_clock_partner partner_u (.clock_i(clock_i), .rstn_i(rstn_i),
        .loop_enable_i(loop_en_o), .external_alive_i(ext_alive),
        .loop_tick_o(loop_tick), .internal_tick_o(int_tick),
        .external_tick_o(ext_tick), .oscillator_done_o(osc_done));

    ////////////////////////////////////////////////////////////////////
    // Clock at 100 ns period
    initial
    begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic tally_and_finish();
        if (num_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic chk8(input string n, input logic [7:0] e, logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask : chk8

    task automatic chkm(input icsm_mode_type e, input icsm_mode_type g);
        check_count++;
        if (g !== e)
        begin
            $display("MISMATCH mode expected %s seen %s", e.name, g.name);
            num_errors++;
        end
    endtask : chkm

    // One-cycle register strobes, read data taken the cycle after
    task automatic acc(input logic w, input logic [1:0] a, logic [7:0] v);
        @(posedge clock_i);
        bus_i <= '{wr: w, rd: !w, addr: a, wdata: v};
        @(posedge clock_i);
        bus_i <= '0;
        #1 d = rdata_o;
    endtask : acc

    task automatic wait_state(input icsm_mode_type m, input logic [1:0] s);
        int i;
        d = 8'hFF;
        for (i = 0; i < 80 && (d[3:2] !== s || mode_o !== m); i++)
            acc(1'b0, ADDR_STATUS, 8'h00);
        if (i == 80)
        begin
            num_errors++;
            tally_and_finish();
        end
        chk8("status mode", {6'h0, s}, {6'h0, d[3:2]});
        chkm(m, mode_o);
    endtask : wait_state

    task automatic count_ticks(input int n);
        {c_gen, c_dbg, c_int, c_ext, c_rst, c_ref} = '0;
        repeat (n)
        begin
            @(posedge clock_i);
            #1;
            c_gen = c_gen + {7'h0, gen_o};
            c_dbg = c_dbg + {7'h0, dbg_o};
            c_int = c_int + {7'h0, int_o};
            c_ext = c_ext + {7'h0, ext_o};
            c_rst = c_rst + {7'h0, restart_o};
            c_ref = c_ref + {7'h0, ref_o};
        end
    endtask : count_ticks

    ////////////////////////////////////////////////////////////////////
    // Hang guard
    initial
    begin
        repeat (100000) @(posedge clock_i);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        {rstn_i, chip_stop_i, debug_i, ext_alive} = 4'h0;
        bus_i = '0;
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        foreach (rows[i])
        begin
            acc(1'b1, rows[i].addr, rows[i].wdata);
            acc(1'b0, rows[i].addr, 8'h00);
            chk8("readback", rows[i].rexp, d);
        end
        chk8("coarse trim", 8'hA5, trim_o);
        // Second reset: trims survive, controls restart
        @(posedge clock_i);
        rstn_i <= 1'b0;
        repeat (10) @(posedge clock_i);
        rstn_i <= 1'b1;
        chk8("trim kept", 8'hA5, trim_o);
        chk8("fine kept", 8'h01, {7'h0, fine_o});
        acc(1'b0, ADDR_CONTROL1, 8'h00);
        chk8("control1 reset", CONTROL1_RESET, d);
        acc(1'b0, ADDR_CONTROL2, 8'h00);
        chk8("control2 reset", CONTROL2_RESET, d);
        chkm(internal_engaged_mode, mode_o);
        // Internal bypass; divider kept at 000 with every select change
        acc(1'b1, ADDR_CONTROL1, 8'h46);
        acc(1'b0, ADDR_STATUS, 8'h00);
        chk8("status early", 8'h01, d);
        wait_state(internal_bypass_mode, SRC_INTERNAL);
        chk8("loop on", 8'h01, {7'h0, loop_en_o});
        acc(1'b1, ADDR_CONTROL2, 8'h48);
        wait_state(internal_bypass_low_power_mode, SRC_INTERNAL);
        count_ticks(40);
        chk8("loop off", 8'h00, {7'h0, loop_en_o});
        chk8("debug ticks", 8'h00, c_dbg);
        @(posedge clock_i);
        debug_i <= 1'b1;
        wait_state(internal_bypass_mode, SRC_INTERNAL);
        @(posedge clock_i);
        debug_i <= 1'b0;
        acc(1'b1, ADDR_CONTROL2, 8'h40);
        // External bypass with dead oscillator: old source kept
        acc(1'b1, ADDR_CONTROL1, 8'h82);
        count_ticks(60);
        wait_state(internal_bypass_mode, SRC_INTERNAL);
        @(posedge clock_i);
        ext_alive <= 1'b1;
        acc(1'b1, ADDR_CONTROL2, 8'h46);
        wait_state(external_bypass_mode, SRC_EXTERNAL);
        count_ticks(30);
        acc(1'b0, ADDR_STATUS, 8'h00);
        chk8("ready set", 8'h0B, d);
        acc(1'b1, ADDR_CONTROL2, 8'h42);
        count_ticks(2);
        acc(1'b0, ADDR_STATUS, 8'h00);
        chk8("ready clear", 8'h09, d);
        // Reserved select acts as loop output
        acc(1'b1, ADDR_CONTROL1, 8'hC6);
        wait_state(internal_engaged_mode, SRC_LOOP);
        count_ticks(40);
        chk8("loop out", 8'h01, {7'h0, |c_gen && |c_dbg});
        // Loop reference change triggers one relock
        acc(1'b1, ADDR_CONTROL1, 8'h02);
        count_ticks(100);
        chk8("relock", 8'h01, c_rst);
        wait_state(external_engaged_mode, SRC_LOOP);
        // Enable bit off: the engaged mode alone keeps it running
        acc(1'b1, ADDR_CONTROL2, 8'h00);
        count_ticks(80);
        chk8("ext run", 8'h01, {7'h0, erun_o});
        chk8("bus div 1", 8'h28, c_gen);
        chk8("ref div 1", 8'h0A, c_ref);
        // Reference divide-by-2 and bus divide-by-8
        acc(1'b1, ADDR_CONTROL1, 8'h0A);
        acc(1'b1, ADDR_CONTROL2, 8'hC0);
        count_ticks(80);
        chk8("bus div 8", 8'h05, c_gen);
        chk8("ref div 2", 8'h05, c_ref);
        // Stop with and without keepalive bits
        acc(1'b1, ADDR_CONTROL1, 8'h07);
        acc(1'b1, ADDR_CONTROL2, 8'h43);
        @(posedge clock_i);
        chip_stop_i <= 1'b1;
        count_ticks(4);
        count_ticks(80);
        chk8("stop gen", 8'h00, c_gen | c_dbg);
        chk8("stop int", 8'h01, {7'h0, |c_int});
        chk8("stop ext", 8'h01, {7'h0, |c_ext});
        chk8("stop int run", 8'h01, {7'h0, irun_o});
        acc(1'b1, ADDR_CONTROL1, 8'h06);
        acc(1'b1, ADDR_CONTROL2, 8'h42);
        count_ticks(4);
        count_ticks(80);
        chk8("stop quiet", 8'h00, c_int | c_ext);
        chk8("stop int idle", 8'h00, {7'h0, irun_o});
        tally_and_finish();
    end
endmodule : tb_internal_clock_source_modes
